// ---- inc/pchif_defs.svh ----
// constants of the phase change memory host controller
`ifndef PCHIF_DEFS_SVH
`define PCHIF_DEFS_SVH
`define PCHIF_ADDR_W 23
`define PCHIF_DATA_W 16
`define PCHIF_CLK_NS 20
`define PCHIF_RD_NS 135
`define PCHIF_RD_CYC ((`PCHIF_RD_NS + `PCHIF_CLK_NS - 1) / `PCHIF_CLK_NS)
`define PCHIF_WR_NS 60
`define PCHIF_WR_CYC ((`PCHIF_WR_NS + `PCHIF_CLK_NS - 1) / `PCHIF_CLK_NS)
`define PCHIF_CNT_W 4
`define PCHIF_SPI_DIV 2
`define PCHIF_BIT_W 3
`endif

// ---- inc/pchif_pkg.sv ----
// types of the phase change memory host controller
package pchif_pkg;
   typedef enum logic [2:0] {st_idle, st_rd_setup, st_rd_wait, st_wr_setup, st_wr_pulse, st_wr_hold} pchif_par_e;
   typedef enum logic [1:0] {sp_idle, sp_low, sp_high, sp_end} pchif_spi_e;
endpackage : pchif_pkg

// ---- hdl/pchif_spi.sv ----
// serial programming port byte engine of the host controller
`timescale 1ns/1ps
`include "pchif_defs.svh"
module pchif_spi (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic start,
   input wire logic last,
   input wire logic pause,
   input wire logic [7:0] tx_byte,
   input wire logic miso_sync,
   output logic busy,
   output logic done,
   output logic [7:0] rx_byte,
   output logic sel_n,
   output logic sclk,
   output logic mosi,
   output logic hold_n
);
   typedef struct packed {
      pchif_pkg::pchif_spi_e st;
      logic [7:0] sh;
      logic [7:0] rx;
      logic [`PCHIF_BIT_W-1:0] bitn;
      logic [1:0] div;
      logic lst;
      logic done;
      logic sel_n;
      logic sclk;
      logic mosi;
      logic hold_n;
      logic [1:0] hold_d;
      logic busy;
   } pchif_spi_s;
   pchif_spi_s r, next_r;
   logic run;

   // clock resumes only after hold_n has been high again through both hold_d delay stages
   assign run = !pause && r.hold_n && (&r.hold_d);

   // ----------------------------------------
   // shift engine: msb first out, sample on rising clock edge of the far end
   // ----------------------------------------
   always_comb begin
      next_r = r;
      next_r.done = 1'b0;
      next_r.hold_n = ~pause;
      next_r.hold_d = {r.hold_d[0], r.hold_n};
      unique case (r.st)
         pchif_pkg::sp_idle: begin
            if (start) begin
               next_r.sel_n = 1'b0;                    // [RULE11]
               next_r.sh = tx_byte;
               next_r.mosi = tx_byte[7];                // [RULE13]
               next_r.bitn = '0;
               next_r.div = '0;
               next_r.lst = last;
               next_r.st = pchif_pkg::sp_low;
            end
         end
         pchif_pkg::sp_low: begin
            if (run) begin                              // [RULE12]
               next_r.div = r.div + 2'h1;
               if (r.div == 2'(`PCHIF_SPI_DIV - 1)) begin
                  next_r.div = '0;
                  next_r.sclk = 1'b1;                   // rising edge: far end samples mosi
                  next_r.st = pchif_pkg::sp_high;
               end
            end
         end
         pchif_pkg::sp_high: begin
            if (run) begin                              // [RULE12]
               next_r.div = r.div + 2'h1;
               if (r.div == 2'(`PCHIF_SPI_DIV - 1)) begin
                  next_r.div = '0;
                  next_r.sclk = 1'b0;                   // falling edge: far end shifts next bit
                  next_r.rx = {r.rx[6:0], miso_sync};   // [RULE14]
                  next_r.sh = {r.sh[6:0], 1'b0};
                  next_r.mosi = r.sh[6];                // [RULE13]
                  next_r.bitn = r.bitn + 3'h1;
                  next_r.st = pchif_pkg::sp_low;
                  if (r.bitn == 3'h7) begin
                     next_r.done = 1'b1;
                     next_r.st = r.lst ? pchif_pkg::sp_end : pchif_pkg::sp_idle;
                  end
               end
            end
         end
         pchif_pkg::sp_end: begin
            next_r.sel_n = 1'b1;                        // [RULE11]
            next_r.st = pchif_pkg::sp_idle;
         end
      endcase
      next_r.busy = (next_r.st != pchif_pkg::sp_idle);
   end

   // ----------------------------------------
   // state register
   // ----------------------------------------
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         r <= '{st: pchif_pkg::sp_idle, sel_n: 1'b1, hold_n: 1'b1, hold_d: 2'h3, default: '0};
      end else begin
         r <= next_r;
      end
   end

   assign busy = r.busy;
   assign done = r.done;
   assign rx_byte = r.rx;
   assign sel_n = r.sel_n;
   assign sclk = r.sclk;
   assign mosi = r.mosi;
   assign hold_n = r.hold_n;
endmodule : pchif_spi

// ---- hdl/pchif_host.sv ----
// host controller for a parallel phase change memory with serial programming port
// Rules of the document this block follows
// [RULE1] word address on lines 23 down to 1
// [RULE2] device drives reads, floats when deselected
// [RULE3] chip select low activates, high is standby
// [RULE4] output enable low gates device drivers
// [RULE5] reset low aborts automation, refuses writes
// [RULE6] device starts in page array read
// [RULE7] address and data valid at strobe rise
// [RULE8] protect low enforces lock-down
// [RULE9] protect high lets locked-down blocks unlock
// [RULE10] protect low again restores lock-down
// [RULE11] serial select low starts, high ends command
// [RULE12] pause input suspends serial cycle
// [RULE13] serial input msb first, sampled rising
// [RULE14] serial output changes on falling clock
// [RULE15] port select chooses parallel or serial
// [RULE16] never assert output enable with strobe
// [RULE17] hold select and address whole cycle
`timescale 1ns/1ps
`include "pchif_defs.svh"
module pchif_host (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic req,
   input wire logic req_write,
   input wire logic [`PCHIF_ADDR_W-1:0] req_addr,
   input wire logic [`PCHIF_DATA_W-1:0] req_wdata,
   output logic ack,
   output logic [`PCHIF_DATA_W-1:0] rdata,
   input wire logic mem_reset_req,
   input wire logic protect_req,
   input wire logic serial_mode_req,
   input wire logic spi_start,
   input wire logic spi_last,
   input wire logic spi_pause,
   input wire logic [7:0] spi_tx,
   output logic spi_busy,
   output logic spi_done,
   output logic [7:0] spi_rx,
   output logic [`PCHIF_ADDR_W-1:0] mem_addr,
   input wire logic [`PCHIF_DATA_W-1:0] mem_dq_in,
   output logic [`PCHIF_DATA_W-1:0] mem_dq_out,
   output logic mem_dq_oe,
   output logic mem_sel_n,
   output logic mem_oe_n,
   output logic mem_we_n,
   output logic mem_rst_n,
   output logic mem_wp_n,
   output logic mem_port_sel,
   output logic spi_sclk,
   output logic spi_mosi,
   output logic spi_hold_n,
   input wire logic spi_miso
);
   // every flop of the block outside the serial engine lives in this one record
   typedef struct packed {
      pchif_pkg::pchif_par_e st;
      logic [`PCHIF_CNT_W-1:0] cnt;
      logic [`PCHIF_ADDR_W-1:0] addr;
      logic [`PCHIF_DATA_W-1:0] dq_out;
      logic [`PCHIF_DATA_W-1:0] rdata;
      logic [`PCHIF_DATA_W-1:0] dq_s1;
      logic [`PCHIF_DATA_W-1:0] dq_s2;
      logic miso_s1;
      logic miso_s2;
      logic dq_oe;
      logic sel_n;
      logic oe_n;
      logic we_n;
      logic rst_n;
      logic wp_n;
      logic port_sel;
      logic ack;
   } pchif_host_s;
   pchif_host_s r, next_r;
   logic spi_sel_n;
   logic spi_sclk_i;
   logic spi_mosi_i;
   logic spi_hold_i;

   // ----------------------------------------
   // count helper: load a wait count in cycles
   // ----------------------------------------
   // cuts the cycle count to the counter width on purpose
   function automatic logic [`PCHIF_CNT_W-1:0] pchif_wait(input int unsigned cyc);
      pchif_wait = `PCHIF_CNT_W'(cyc);
   endfunction : pchif_wait

   // ----------------------------------------
   // serial engine; select is shared with the parallel chip select pin
   // ----------------------------------------
   pchif_spi u_spi (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .start(spi_start & r.port_sel),                // [RULE15]
      .last(spi_last),
      .pause(spi_pause),
      .tx_byte(spi_tx),
      .miso_sync(r.miso_s2),
      .busy(spi_busy),
      .done(spi_done),
      .rx_byte(spi_rx),
      .sel_n(spi_sel_n),
      .sclk(spi_sclk_i),
      .mosi(spi_mosi_i),
      .hold_n(spi_hold_i)
   );

   // ----------------------------------------
   // parallel cycle sequencer
   // ----------------------------------------
   always_comb begin
      next_r = r;
      next_r.ack = 1'b0;
      // pin inputs pass two flops; only the second stage is read
      next_r.dq_s1 = mem_dq_in;
      next_r.dq_s2 = r.dq_s1;
      next_r.miso_s1 = spi_miso;
      next_r.miso_s2 = r.miso_s1;
      next_r.wp_n = ~protect_req;                     // [RULE8] [RULE9] [RULE10]
      next_r.rst_n = ~mem_reset_req;                  // [RULE5] [RULE6]
      // port select moves only while both engines rest
      if (r.st == pchif_pkg::st_idle && !spi_busy) begin
         next_r.port_sel = serial_mode_req;           // [RULE15]
      end
      // the chip select pin carries the serial select in serial mode
      next_r.sel_n = r.port_sel ? spi_sel_n : 1'b1;    // [RULE11]
      unique case (r.st)
         pchif_pkg::st_idle: begin
            if (req && !r.port_sel && r.rst_n && !mem_reset_req) begin
               next_r.addr = req_addr;                 // [RULE1]
               next_r.sel_n = 1'b0;                    // [RULE3]
               next_r.port_sel = 1'b0;                 // a taken cycle keeps the parallel port [RULE15]
               if (req_write) begin
                  next_r.dq_out = req_wdata;
                  next_r.dq_oe = 1'b1;                 // [RULE17]
                  next_r.st = pchif_pkg::st_wr_setup;
               end else begin
                  next_r.st = pchif_pkg::st_rd_setup;
               end
            end
         end
         pchif_pkg::st_rd_setup: begin
            // count covers the access time plus both synchroniser stages
            next_r.sel_n = 1'b0;
            next_r.oe_n = 1'b0;                        // [RULE4] [RULE16]
            next_r.cnt = pchif_wait(`PCHIF_RD_CYC + 2);
            next_r.st = pchif_pkg::st_rd_wait;
         end
         pchif_pkg::st_rd_wait: begin
            // data is taken from the second synchroniser stage at count zero
            next_r.sel_n = 1'b0;                       // [RULE17]
            next_r.cnt = r.cnt - 1'b1;
            if (r.cnt == '0) begin
               next_r.rdata = r.dq_s2;                 // [RULE2]
               next_r.oe_n = 1'b1;
               next_r.sel_n = 1'b1;
               next_r.ack = 1'b1;
               next_r.st = pchif_pkg::st_idle;
            end
         end
         pchif_pkg::st_wr_setup: begin
            // strobe falls with address and data already on the bus
            next_r.sel_n = 1'b0;
            next_r.we_n = 1'b0;                        // [RULE16]
            next_r.cnt = pchif_wait(`PCHIF_WR_CYC);
            next_r.st = pchif_pkg::st_wr_pulse;
         end
         pchif_pkg::st_wr_pulse: begin
            // strobe rises while address and data are still driven
            next_r.sel_n = 1'b0;
            next_r.cnt = r.cnt - 1'b1;
            if (r.cnt == '0) begin
               next_r.we_n = 1'b1;                     // [RULE7]
               next_r.st = pchif_pkg::st_wr_hold;
            end
         end
         pchif_pkg::st_wr_hold: begin
            // bus released one cycle after the strobe rises
            next_r.sel_n = 1'b1;                       // data held one cycle past strobe rise [RULE7]
            next_r.dq_oe = 1'b0;
            next_r.ack = 1'b1;
            next_r.st = pchif_pkg::st_idle;
         end
         default: begin
            // illegal state code falls back to idle
            next_r.st = pchif_pkg::st_idle;
         end
      endcase
   end

   // ----------------------------------------
   // state register
   // ----------------------------------------
   // reset holds the memory in reset with every strobe inactive
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         r <= '{st: pchif_pkg::st_idle, sel_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, wp_n: 1'b1, default: '0};
      end else begin
         r <= next_r;
      end
   end

   // ----------------------------------------
   // pins, all from flip-flops
   // ----------------------------------------
   assign ack = r.ack;
   assign rdata = r.rdata;
   assign mem_addr = r.addr;
   assign mem_dq_out = r.dq_out;
   assign mem_dq_oe = r.dq_oe;
   assign mem_sel_n = r.sel_n;
   assign mem_oe_n = r.oe_n;
   assign mem_we_n = r.we_n;
   assign mem_rst_n = r.rst_n;
   assign mem_wp_n = r.wp_n;
   assign mem_port_sel = r.port_sel;
   // serial pins come straight from the engine's own flops
   assign spi_sclk = spi_sclk_i;
   assign spi_mosi = spi_mosi_i;
   assign spi_hold_n = spi_hold_i;
endmodule : pchif_host

// ---- dv/pchif_host_properties.sv ----
// pin-level assertion checker of the host controller
`timescale 1ns/1ps
`include "pchif_defs.svh"
module pchif_host_properties (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic mem_reset_req,
   input wire logic protect_req,
   input wire logic spi_pause,
   input wire logic spi_busy,
   input wire logic [`PCHIF_ADDR_W-1:0] mem_addr,
   input wire logic [`PCHIF_DATA_W-1:0] mem_dq_out,
   input wire logic mem_dq_oe,
   input wire logic mem_sel_n,
   input wire logic mem_oe_n,
   input wire logic mem_we_n,
   input wire logic mem_rst_n,
   input wire logic mem_wp_n,
   input wire logic mem_port_sel,
   input wire logic spi_sclk,
   input wire logic spi_hold_n
);
   // ------------------------------------------------
   // parallel bus and control pins
   // ------------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   property p_no_oe_we; !(!mem_oe_n && !mem_we_n); endproperty
   a_no_oe_we: assert property (p_no_oe_we) else $error("oe and we low together");
   property p_contend; mem_dq_oe |-> mem_oe_n; endproperty
   a_contend: assert property (p_contend) else $error("host drives dq during read");
   property p_wr_latch; $rose(mem_we_n) |-> mem_dq_oe && !mem_sel_n && $stable(mem_addr) && $stable(mem_dq_out);
   endproperty
   a_wr_latch: assert property (p_wr_latch) else $error("write strobe rise without stable bus");
   property p_we_sel; !mem_we_n |-> !mem_sel_n && mem_rst_n; endproperty
   a_we_sel: assert property (p_we_sel) else $error("strobe low while deselected or reset");
   property p_rst; mem_reset_req |=> !mem_rst_n; endproperty
   a_rst: assert property (p_rst) else $error("reset pin not low");
   property p_wp; mem_wp_n == !$past(protect_req); endproperty
   a_wp: assert property (p_wp) else $error("protect pin wrong");
   property p_port; mem_port_sel |-> mem_oe_n && mem_we_n && !mem_dq_oe; endproperty
   a_port: assert property (p_port) else $error("parallel pins active in serial mode");
   property p_addr; !mem_port_sel && !mem_sel_n && !$past(mem_sel_n) |-> $stable(mem_addr); endproperty
   a_addr: assert property (p_addr) else $error("address moved inside cycle");
   property p_pause; mem_port_sel && spi_busy && spi_pause |=> !spi_hold_n; endproperty
   a_pause: assert property (p_pause) else $error("pause pin not asserted");
   // main scenarios
   c_wr: cover property ($rose(mem_we_n));
   c_rd: cover property ($fell(mem_oe_n));
   c_spi: cover property (mem_port_sel && $fell(spi_sclk));
endmodule : pchif_host_properties
bind pchif_host pchif_host_properties u_props (.clk_sys, .rstn, .mem_reset_req, .protect_req, .spi_pause,
   .spi_busy, .mem_addr, .mem_dq_out, .mem_dq_oe, .mem_sel_n, .mem_oe_n, .mem_we_n, .mem_rst_n, .mem_wp_n,
   .mem_port_sel, .spi_sclk, .spi_hold_n);

// ---- dv/pchif_mem_model.sv ----
// behavioural phase change memory seen from its pins
`timescale 1ns/1ps
`include "pchif_defs.svh"
module pchif_mem_model (
   input wire logic [`PCHIF_ADDR_W-1:0] mem_addr,
   input wire logic [`PCHIF_DATA_W-1:0] mem_dq_out,
   input wire logic mem_dq_oe,
   input wire logic mem_sel_n,
   input wire logic mem_oe_n,
   input wire logic mem_we_n,
   input wire logic mem_rst_n,
   input wire logic mem_port_sel,
   input wire logic spi_sclk,
   input wire logic spi_mosi,
   input wire logic spi_hold_n,
   output logic [`PCHIF_DATA_W-1:0] mem_dq_in,
   output logic spi_miso
);
   logic [15:0] mem [0:15];
   logic [7:0] rx = 8'h00, tx = 8'ha5, rx_last = 8'h5a;
   logic [2:0] cnt = 3'h0;
   logic drv, sdrv;
   // array readable from the start, no command needed
   initial for (int i = 0; i < 16; i++) mem[i] = {4{i[3:0]}};
   // device drives only when selected, output enabled, out of reset, parallel mode
   assign drv = !mem_sel_n && !mem_oe_n && mem_rst_n && !mem_port_sel;
   // floating bus shows the inverse of the host word, never a stale value
   assign mem_dq_in = mem_dq_oe ? mem_dq_out : drv ? mem[mem_addr[3:0]] : ~mem_dq_out;
   always @(posedge mem_we_n) begin
      if (!mem_sel_n && mem_oe_n && mem_rst_n && !mem_port_sel) begin
         mem[mem_addr[3:0]] <= mem_dq_out;
      end
   end
   // serial input shifted in msb first on rising clock
   always @(posedge spi_sclk or posedge mem_sel_n) begin
      if (mem_sel_n) cnt <= 3'h0;
      else if (spi_hold_n && mem_port_sel) begin
         rx <= {rx[6:0], spi_mosi};
         cnt <= cnt + 3'h1;
         if (cnt == 3'h7) rx_last <= {rx[6:0], spi_mosi};
      end
   end
   // reply is the inverse of the last byte, shifted on falling clock
   always @(negedge spi_sclk) begin
      if (cnt == 3'h0) tx <= ~rx_last;
      else if (!mem_sel_n && spi_hold_n) tx <= {tx[6:0], 1'b0};
   end
   assign sdrv = !mem_sel_n && spi_hold_n && mem_port_sel;
   assign spi_miso = sdrv ? tx[7] : ~tx[7];
endmodule : pchif_mem_model

// ---- dv/test_pchif_host.sv ----
// self-checking bench of the host controller
`timescale 1ns/1ps
`include "pchif_defs.svh"
module test_pchif_host;
   logic clk_sys = 0, rstn = 0, req = 0, req_write = 0, mem_reset_req = 0, protect_req = 0, serial_mode_req = 0;
   logic spi_start = 0, spi_last = 0, spi_pause = 0, ack, spi_busy, spi_done, got;
   logic [`PCHIF_ADDR_W-1:0] req_addr = 0, mem_addr, a;
   logic [`PCHIF_DATA_W-1:0] req_wdata = 0, rdata, mem_dq_in, mem_dq_out, d;
   logic [7:0] spi_tx = 0, spi_rx, b1, b2;
   logic mem_dq_oe, mem_sel_n, mem_oe_n, mem_we_n, mem_rst_n, mem_wp_n, mem_port_sel, spi_sclk, spi_mosi;
   logic spi_hold_n, spi_miso;
   logic [15:0] shadow [0:15];
   int n_mismatch = 0, tests_run = 0;
   always #10 clk_sys = ~clk_sys;
   pchif_host dut (.clk_sys, .rstn, .req, .req_write, .req_addr, .req_wdata, .ack, .rdata, .mem_reset_req,
      .protect_req, .serial_mode_req, .spi_start, .spi_last, .spi_pause, .spi_tx, .spi_busy, .spi_done, .spi_rx,
      .mem_addr, .mem_dq_in, .mem_dq_out, .mem_dq_oe, .mem_sel_n, .mem_oe_n, .mem_we_n, .mem_rst_n, .mem_wp_n,
      .mem_port_sel, .spi_sclk, .spi_mosi, .spi_hold_n, .spi_miso);
   pchif_mem_model model (.mem_addr, .mem_dq_out, .mem_dq_oe, .mem_sel_n, .mem_oe_n, .mem_we_n, .mem_rst_n,
      .mem_port_sel, .spi_sclk, .spi_mosi, .spi_hold_n, .mem_dq_in, .spi_miso);
   // ------------------------------------------------
   // helpers
   // ------------------------------------------------
   function automatic logic [15:0] exp_init(input logic [3:0] i);
      return {4{i}};
   endfunction : exp_init
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR %0t ns: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   // one parallel cycle, request held until ack, got tells whether ack came
   task automatic par(input logic wr, input logic [22:0] ad, input logic [15:0] dt);
      @(negedge clk_sys); req = 1; req_write = wr; req_addr = ad; req_wdata = dt;
      got = 0;
      for (int n = 0; n < 30 && !got; n++) begin @(posedge clk_sys); #1 got = (ack === 1'b1); end
      @(negedge clk_sys); req = 0;
   endtask : par
   // one serial byte, optionally paused in the middle
   task automatic spi(input logic [7:0] b, input logic lst, input logic p);
      @(negedge clk_sys); spi_start = 1; spi_tx = b; spi_last = lst;
      @(negedge clk_sys); spi_start = 0;
      if (p) begin repeat (5) @(negedge clk_sys); spi_pause = 1; repeat (8) @(negedge clk_sys); spi_pause = 0; end
      got = 0;
      for (int n = 0; n < 80 && !got; n++) begin @(posedge clk_sys); #1 got = (spi_done === 1'b1); end
      check(16'(got), 16'h1);
   endtask : spi
   task automatic test_done;
      $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : test_done
   // ------------------------------------------------
   // tests
   // ------------------------------------------------
   initial begin
      void'($urandom(25));
      for (int i = 0; i < 16; i++) shadow[i] = exp_init(i[3:0]);
      repeat (8) @(posedge clk_sys);
      #1 check({14'h0, mem_rst_n, mem_sel_n}, 16'h1);
      repeat (9) @(negedge clk_sys);
      rstn = 1;
      a = 23'($urandom); par(0, a, 0); check(rdata, shadow[a[3:0]]);
      $display("test read after reset done");
      for (int k = 0; k < 8; k++) begin
         a = (k == 0) ? 23'h7fffff : (k == 1) ? 23'h0 : 23'($urandom);
         d = (k == 0) ? 16'hffff : (k == 1) ? 16'h0 : 16'($urandom);
         par(1, a, d); check(16'(got), 16'h1);
         shadow[a[3:0]] = d;
         par(0, a, 0); check(rdata, d);
      end
      $display("test write read done");
      @(negedge clk_sys); mem_reset_req = 1;
      par(1, a, ~d); check({mem_rst_n, got}, 16'h0);
      @(negedge clk_sys); mem_reset_req = 0;
      repeat (3) @(negedge clk_sys);
      par(0, a, 0); check(rdata, shadow[a[3:0]]);
      $display("test reset refuses writes done");
      @(negedge clk_sys); protect_req = 1;
      repeat (2) @(negedge clk_sys); check(16'(mem_wp_n), 16'h0);
      protect_req = 0;
      repeat (2) @(negedge clk_sys); check(16'(mem_wp_n), 16'h1);
      $display("test protect done");
      serial_mode_req = 1;
      repeat (4) @(negedge clk_sys); check(16'(mem_port_sel), 16'h1);
      par(0, a, 0); check(16'(got), 16'h0);
      b1 = 8'($urandom); b2 = 8'($urandom);
      spi(b1, 0, 0); check({8'h00, spi_rx}, 16'h00a5);
      check({8'h00, model.rx_last}, {8'h00, b1});
      check(16'(spi_busy), 16'h0);
      spi(b2, 1, 1); check({8'h00, spi_rx}, {8'h00, ~b1});
      check({8'h00, model.rx_last}, {8'h00, b2});
      repeat (3) @(negedge clk_sys); check(16'(mem_sel_n), 16'h1);
      serial_mode_req = 0;
      $display("test serial done");
      test_done();
   end
   // watchdog
   initial begin
      #200us;
      n_mismatch++;
      test_done();
   end
endmodule : test_pchif_host
